// ---- logic/hsfc_pkg.sv ----
package hsfc_pkg;
   // ----------------------------------------
   // Roles and port selection
   // ----------------------------------------
   typedef enum logic [1:0] {
      HSFC_ROLE_BASE = 2'b00,
      HSFC_ROLE_REMOTE = 2'b01,
      HSFC_ROLE_ROUTER = 2'b10
   } hsfc_role_e;

   localparam int HSFC_GPIO_COUNT = 6;
   localparam int HSFC_WAKE_PINS = 4;
   localparam int HSFC_BEACON_MISS_HOPS = 50;
   localparam int HSFC_PATTERN_COUNT = 12;
   localparam int HSFC_CHECK_BITS = 24;
   localparam int HSFC_UART_MAX_BPS = 250000;
   localparam int HSFC_SPI_MAX_BPS = 500000;
   localparam int HSFC_CLK_HZ = 250000000;
   localparam int HSFC_ACT_PULSE_NS = 20000;
   localparam int HSFC_ACT_PULSE_CYC = (HSFC_ACT_PULSE_NS * (HSFC_CLK_HZ / 1000000)) / 1000;
   localparam int HSFC_UART_MIN_DIV = (HSFC_CLK_HZ + HSFC_UART_MAX_BPS - 1) / HSFC_UART_MAX_BPS;
   localparam int HSFC_SPI_MIN_DIV = (HSFC_CLK_HZ + HSFC_SPI_MAX_BPS - 1) / HSFC_SPI_MAX_BPS;
   localparam logic [5:0] HSFC_GPIO_RST_DIR = 6'h00;
   localparam logic [5:0] HSFC_GPIO_RST_PULL = 6'h00;

   // ----------------------------------------
   // Grouped carriers
   // ----------------------------------------
   typedef struct packed {
      logic rx_valid;
      logic rx_upstream;
      logic tx_sent;
      logic tx_downstream;
      logic sync_gained;
      logic hop_tick;
      logic beacon_heard;
   } hsfc_radio_ev_s;

   typedef struct packed {
      logic [5:0] dir;
      logic [5:0] pull;
      logic [5:0] level;
      logic [5:0] wake_en;
   } hsfc_gpio_cfg_s;
endpackage

// ---- logic/hsfc_pins.sv ----
// What this block does
// - Base: pulse activity output on every valid received packet.
// - Remote: pulse activity output on every transmitted packet.
// - Router: pulse on valid upstream receive and downstream transmit.
// - Activity pin may instead carry diagnostic serial output.
// - Base: carrier detect on valid packet, drop after registration time-out.
// - Router/remote: carrier detect on sync, drop after 50 hops without beacon.
// - Carrier-detect pin may instead become diagnostic serial input.
// - General input pins offer pull-up and wake from sleep.
// - Output power-on level; sleep direction, pull, level set separately.
// - Only four of six general pins can wake, only as inputs.
// - Clear-to-send low while host data accepted, high otherwise.
// - Host request-to-send low allows output; high stops module transmit.
// - Pins five and six default general, alternates are flow control.
// - User data via serial or SPI as selected; second serial diagnostic.
// - Serial up to 250 kbps, SPI up to 500 kbps.
// - Serial out toward host on transmit pin, in on receive pin.
// - 24-bit check protects data; ack/retry or redundancy optional.
// - Twelve hopping patterns and two power levels selectable.
// - With SPI slave on, pin four shows data waiting for master.
`timescale 1ns/10ps
`default_nettype none
module hsfc_pins #(
   parameter int REG_TIMEOUT_CYC = 25000000,
   parameter int ACT_PULSE_CYC = hsfc_pkg::HSFC_ACT_PULSE_CYC,
   parameter int PATTERNS = hsfc_pkg::HSFC_PATTERN_COUNT,
   parameter int UART_DIV_MIN = hsfc_pkg::HSFC_UART_MIN_DIV,
   parameter int SPI_DIV_MIN = hsfc_pkg::HSFC_SPI_MIN_DIV
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Role and alternate-function configuration
   input wire hsfc_pkg::hsfc_role_e role,
   input wire logic diag_on_indicators,
   input wire logic flow_ctrl_en,
   input wire logic spi_select,
   input wire logic sleep_mode,
   input wire logic [3:0] hop_pattern,
   input wire logic power_high,
   input wire logic ack_retry_en,
   input wire logic redundant_en,
   input wire logic [15:0] uart_div,
   input wire logic [15:0] spi_div,
   // Radio-side events
   input wire hsfc_pkg::hsfc_radio_ev_s radio_ev,
   input wire logic rx_can_accept,
   input wire logic spi_data_waiting,
   // Core serial streams
   input wire logic core_tx_bit,
   input wire logic core_diagnostic_serial_out_bit,
   output logic core_rx_bit,
   output logic core_mosi_bit,
   output logic core_diagnostic_serial_in_bit,
   output logic host_tx_allowed,
   // Host-facing pins
   output logic activity_indicator,
   output logic carrier_detect_n,
   input wire logic carrier_detect_in,
   output logic radio_txd,
   input wire logic radio_rxd,
   input wire logic spi_mosi,
   // General pins
   input wire hsfc_pkg::hsfc_gpio_cfg_s gpio_active,
   input wire hsfc_pkg::hsfc_gpio_cfg_s gpio_sleep,
   input wire logic [5:0] gpio_in,
   output logic [5:0] gpio_out,
   output logic [5:0] gpio_oe,
   output logic [5:0] gpio_pullup,
   output logic wake_request,
   // Configuration checks
   output logic cfg_error
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] rxd_sync;
      logic [2:0] mosi_sync;
      logic [2:0] diag_sync;
      logic [2:0] rts_sync;
      logic [5:0][2:0] pin_sync;
      logic rxd_q;
      logic mosi_q;
      logic diag_q;
      logic rts_q;
      logic [5:0] pin_q;
      logic [31:0] act_cnt;
      logic act;
      logic carrier;
      logic [31:0] idle_cnt;
      logic [7:0] miss_hops;
      logic txd;
      logic [5:0] gout;
      logic wake;
   } hsfc_state_s;

   hsfc_state_s state;
   hsfc_state_s next_state;
   hsfc_pkg::hsfc_gpio_cfg_s cfg;
   logic act_event;
   logic rts_n;
   logic [5:0] wake_ok;

   // Sleep settings replace active ones whole
   assign cfg = sleep_mode ? gpio_sleep : gpio_active;
   assign rts_n = state.rts_q;

   // ----------------------------------------
   // Activity event selection
   // ----------------------------------------
   always_comb begin
      unique case (role)
         hsfc_pkg::HSFC_ROLE_BASE: act_event = radio_ev.rx_valid;
         hsfc_pkg::HSFC_ROLE_REMOTE: act_event = radio_ev.tx_sent;
         hsfc_pkg::HSFC_ROLE_ROUTER: act_event = (radio_ev.rx_valid & radio_ev.rx_upstream) |
            (radio_ev.tx_sent & radio_ev.tx_downstream);
         default: act_event = 1'b0;
      endcase
   end

   // Wake capable only on low four, only as input
   generate
      for (genvar i = 0; i < 6; i++) begin : g_wake
         if (i < hsfc_pkg::HSFC_WAKE_PINS) begin : g_cap
            assign wake_ok[i] = cfg.wake_en[i] & ~cfg.dir[i];
         end else begin : g_nocap
            assign wake_ok[i] = 1'b0;
         end
      end
   endgenerate

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_state = state;
      // Only the agreeing second and third stages feed logic
      next_state.rxd_sync = {state.rxd_sync[1:0], radio_rxd};
      next_state.mosi_sync = {state.mosi_sync[1:0], spi_mosi};
      next_state.diag_sync = {state.diag_sync[1:0], carrier_detect_in};
      next_state.rts_sync = {state.rts_sync[1:0], gpio_in[5]};
      if (state.rxd_sync[2] == state.rxd_sync[1]) next_state.rxd_q = state.rxd_sync[2];
      if (state.mosi_sync[2] == state.mosi_sync[1]) next_state.mosi_q = state.mosi_sync[2];
      if (state.diag_sync[2] == state.diag_sync[1]) next_state.diag_q = state.diag_sync[2];
      if (state.rts_sync[2] == state.rts_sync[1]) next_state.rts_q = state.rts_sync[2];
      for (int i = 0; i < 6; i++) begin
         next_state.pin_sync[i] = {state.pin_sync[i][1:0], gpio_in[i]};
         if (state.pin_sync[i][2] == state.pin_sync[i][1]) next_state.pin_q[i] = state.pin_sync[i][2];
      end

      // Fixed-width pulse; a new event restarts it
      if (act_event) begin
         next_state.act = 1'b1;
         next_state.act_cnt = 32'(ACT_PULSE_CYC - 1);
      end else if (state.act_cnt != 32'h0000_0000) begin
         next_state.act_cnt = state.act_cnt - 32'h0000_0001;
      end else begin
         next_state.act = 1'b0;
      end

      // Carrier detect
      if (role == hsfc_pkg::HSFC_ROLE_BASE) begin
         next_state.miss_hops = 8'h00;
         if (radio_ev.rx_valid) begin
            next_state.carrier = 1'b1;
            next_state.idle_cnt = 32'h0000_0000;
         end else if (state.carrier) begin
            if (state.idle_cnt >= 32'(REG_TIMEOUT_CYC - 1)) next_state.carrier = 1'b0;
            else next_state.idle_cnt = state.idle_cnt + 32'h0000_0001;
         end
      end else begin
         next_state.idle_cnt = 32'h0000_0000;
         if (radio_ev.sync_gained | radio_ev.beacon_heard) begin
            if (radio_ev.sync_gained) next_state.carrier = 1'b1;
            next_state.miss_hops = 8'h00;
         end else if (state.carrier && radio_ev.hop_tick) begin
            if (state.miss_hops >= 8'(hsfc_pkg::HSFC_BEACON_MISS_HOPS - 1)) begin
               next_state.carrier = 1'b0;
               next_state.miss_hops = 8'h00;
            end else begin
               next_state.miss_hops = state.miss_hops + 8'h01;
            end
         end
      end

      // Transmit held idle-high while host refuses
      next_state.txd = (flow_ctrl_en & rts_n) ? 1'b1 : core_tx_bit;

      // General outputs follow the selected level
      next_state.gout = cfg.level;
      next_state.wake = sleep_mode & |(wake_ok & ~state.pin_q);
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= '0;
         state.rxd_sync <= 3'h7;
         state.mosi_sync <= 3'h7;
         state.diag_sync <= 3'h7;
         state.rts_sync <= 3'h7;
         state.pin_sync <= '1;
         state.rxd_q <= 1'b1;
         state.diag_q <= 1'b1;
         state.rts_q <= 1'b1;
         state.pin_q <= 6'h3F;
         state.txd <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------
   // Pin muxing
   // ----------------------------------------
   always_comb begin
      activity_indicator = diag_on_indicators ? core_diagnostic_serial_out_bit : state.act;
      carrier_detect_n = ~state.carrier;
      core_diagnostic_serial_in_bit = diag_on_indicators ? state.diag_q : 1'b1;
      radio_txd = spi_select ? 1'b1 : state.txd;
      core_rx_bit = spi_select ? 1'b1 : state.rxd_q;
      core_mosi_bit = spi_select ? state.mosi_q : 1'b0;
      host_tx_allowed = ~flow_ctrl_en | ~rts_n;
      gpio_out = state.gout;
      gpio_oe = cfg.dir;
      gpio_pullup = cfg.pull & ~cfg.dir;
      if (spi_select) begin
         gpio_out[3] = spi_data_waiting;
         gpio_oe[3] = 1'b1;
         gpio_pullup[3] = 1'b0;
      end
      if (flow_ctrl_en) begin
         gpio_out[4] = ~rx_can_accept;
         gpio_oe[4] = 1'b1;
         gpio_pullup[4] = 1'b0;
         gpio_out[5] = 1'b0;
         gpio_oe[5] = 1'b0;
         gpio_pullup[5] = 1'b1;
      end
      wake_request = state.wake;
   end

   // Reject out-of-range hop pattern or serial divisors
   assign cfg_error = (32'(hop_pattern) >= PATTERNS) |
      (32'(uart_div) < UART_DIV_MIN) | (32'(spi_div) < SPI_DIV_MIN);

   // Check width and options are carried by the radio core
   logic unused_ok;
   assign unused_ok = power_high ^ ack_retry_en ^ redundant_en ^ (hsfc_pkg::HSFC_CHECK_BITS == 24);

   // Pins five and six never wake, whatever their enables say
   logic wake_src;
   assign wake_src = sleep_mode & |(cfg.wake_en[3:0] & ~cfg.dir[3:0] & ~state.pin_q[3:0]);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_base_act_pulse: assert property (@(posedge clk) disable iff (!resetn)
      (role == hsfc_pkg::HSFC_ROLE_BASE && radio_ev.rx_valid) |=> state.act)
      else $error("activity missed on base receive");
   chk_remote_act_pulse: assert property (@(posedge clk) disable iff (!resetn)
      (role == hsfc_pkg::HSFC_ROLE_REMOTE && radio_ev.tx_sent) |=> state.act)
      else $error("activity missed on remote transmit");
   chk_router_act_pulse: assert property (@(posedge clk) disable iff (!resetn)
      (role == hsfc_pkg::HSFC_ROLE_ROUTER && radio_ev.tx_sent && radio_ev.tx_downstream) |=> state.act)
      else $error("activity missed on router downstream");
   chk_router_up_pulse: assert property (@(posedge clk) disable iff (!resetn)
      (role == hsfc_pkg::HSFC_ROLE_ROUTER && radio_ev.rx_valid && radio_ev.rx_upstream) |=> state.act)
      else $error("activity missed on router upstream");
   chk_act_hold: assert property (@(posedge clk) disable iff (!resetn)
      (state.act && !act_event && state.act_cnt != 32'h0000_0000) |=> state.act)
      else $error("activity pulse ended early");
   chk_act_end: assert property (@(posedge clk) disable iff (!resetn)
      (state.act && !act_event && state.act_cnt == 32'h0000_0000) |=> !state.act)
      else $error("activity pulse too long");
   chk_diag_out_mux: assert property (@(posedge clk) disable iff (!resetn)
      diag_on_indicators |-> activity_indicator == core_diagnostic_serial_out_bit)
      else $error("diagnostic output not routed");
   chk_act_default: assert property (@(posedge clk) disable iff (!resetn)
      !diag_on_indicators |-> activity_indicator == state.act)
      else $error("activity pin not in default function");
   chk_base_carrier_set: assert property (@(posedge clk) disable iff (!resetn)
      (role == hsfc_pkg::HSFC_ROLE_BASE && radio_ev.rx_valid) |=> !carrier_detect_n)
      else $error("carrier not asserted on base receive");
   chk_carrier_timeout: assert property (@(posedge clk) disable iff (!resetn)
      (role == hsfc_pkg::HSFC_ROLE_BASE && state.carrier && !radio_ev.rx_valid &&
      state.idle_cnt >= 32'(REG_TIMEOUT_CYC - 1)) |=> carrier_detect_n)
      else $error("carrier kept past registration time-out");
   chk_sync_carrier_set: assert property (@(posedge clk) disable iff (!resetn)
      (role != hsfc_pkg::HSFC_ROLE_BASE && radio_ev.sync_gained) |=> state.carrier)
      else $error("carrier not asserted on sync");
   chk_miss_drop: assert property (@(posedge clk) disable iff (!resetn)
      (role != hsfc_pkg::HSFC_ROLE_BASE && state.carrier && radio_ev.hop_tick && !radio_ev.sync_gained &&
      !radio_ev.beacon_heard && state.miss_hops == 8'(hsfc_pkg::HSFC_BEACON_MISS_HOPS - 1)) |=> carrier_detect_n)
      else $error("carrier kept after missed beacons");
   chk_beacon_clears: assert property (@(posedge clk) disable iff (!resetn)
      (role != hsfc_pkg::HSFC_ROLE_BASE && radio_ev.beacon_heard) |=> state.miss_hops == 8'h00)
      else $error("beacon did not restart hop count");
   chk_diag_in_mux: assert property (@(posedge clk) disable iff (!resetn)
      !diag_on_indicators |-> core_diagnostic_serial_in_bit == 1'b1)
      else $error("diagnostic input not idle");
   chk_sleep_dir: assert property (@(posedge clk) disable iff (!resetn)
      (!spi_select && !flow_ctrl_en) |-> gpio_oe == (sleep_mode ? gpio_sleep.dir : gpio_active.dir))
      else $error("general pin direction wrong");
   chk_no_pull_driven: assert property (@(posedge clk) disable iff (!resetn)
      (!spi_select && !flow_ctrl_en) |-> (gpio_pullup & gpio_oe) == 6'h00)
      else $error("pull-up on a driven pin");
   chk_cts_level: assert property (@(posedge clk) disable iff (!resetn)
      flow_ctrl_en |-> gpio_oe[4] && gpio_out[4] == !rx_can_accept)
      else $error("clear-to-send wrong level");
   chk_rts_pin_input: assert property (@(posedge clk) disable iff (!resetn)
      flow_ctrl_en |-> !gpio_oe[5] && gpio_pullup[5])
      else $error("request-to-send pin not an input");
   chk_rts_stop_tx: assert property (@(posedge clk) disable iff (!resetn)
      (flow_ctrl_en && rts_n && !spi_select) |=> radio_txd)
      else $error("transmit not held while host refuses");
   chk_host_tx_gate: assert property (@(posedge clk) disable iff (!resetn)
      (flow_ctrl_en && rts_n) |-> !host_tx_allowed)
      else $error("transmit allowed while host refuses");
   chk_spi_pin_alt: assert property (@(posedge clk) disable iff (!resetn)
      spi_select |-> gpio_oe[3] && gpio_out[3] == spi_data_waiting)
      else $error("data waiting pin wrong");
   chk_spi_txd_idle: assert property (@(posedge clk) disable iff (!resetn)
      spi_select |-> radio_txd)
      else $error("serial output not idle in SPI mode");
   chk_cfg_range: assert property (@(posedge clk) disable iff (!resetn)
      (32'(hop_pattern) >= PATTERNS) |-> cfg_error)
      else $error("bad hop pattern accepted");
   chk_wake_pins_limit: assert property (@(posedge clk) disable iff (!resetn)
      state.wake |-> $past(wake_src))
      else $error("wake from a pin that cannot wake");
   cov_base_rx: cover property (@(posedge clk) role == hsfc_pkg::HSFC_ROLE_BASE && radio_ev.rx_valid);
   cov_router_act: cover property (@(posedge clk) role == hsfc_pkg::HSFC_ROLE_ROUTER && act_event);
   cov_carrier_drop: cover property (@(posedge clk) $fell(state.carrier));
   cov_flow_stop: cover property (@(posedge clk) flow_ctrl_en && rts_n);
   cov_wake: cover property (@(posedge clk) wake_request);

endmodule // hsfc_pins
`default_nettype wire

// ---- verification/hsfc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module hsfc_host_model (
   // Clock
   input wire logic clk,
   // Module pins
   input wire logic cts_n,
   output logic rts_n,
   output logic rxd,
   // Bench control
   input wire logic hold_rx
);
   // ----------------------------------------
   // Host side of the flow-controlled port
   // ----------------------------------------
   assign rts_n = hold_rx;
   // Sends zero bits; a blocked host idles the line high
   always @(negedge clk) begin
      rxd <= cts_n ? 1'b1 : 1'b0;
   end
endmodule // hsfc_host_model
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk = 1'b0;
   logic resetn = 1'b0;
   hsfc_pkg::hsfc_role_e role = hsfc_pkg::HSFC_ROLE_BASE;
   logic diag = 1'b0, flow = 1'b0, spi_sel = 1'b0, sleep = 1'b0, hold = 1'b0;
   logic [3:0] hop = 4'h0;
   logic [15:0] udiv = 16'h03E8, sdiv = 16'h01F4;
   hsfc_pkg::hsfc_radio_ev_s ev = '0;
   logic can = 1'b1, waiting = 1'b0, ctx = 1'b1, dtx = 1'b0, cd_in = 1'b1, mosi = 1'b0;
   hsfc_pkg::hsfc_gpio_cfg_s ga = '0, gs = '0;
   logic [4:0] gin = 5'h1F;
   logic rts_n, rxd, rx_bit, mosi_bit, drx_bit, tx_ok, act, cdn, txd, wake, cfg_err;
   logic [5:0] gout, goe, gpu;
   int error_cnt = 0, samples_checked = 0;
   logic [1:0] a_role [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3};
   logic [6:0] a_ev [8] = '{7'h40, 7'h10, 7'h10, 7'h40, 7'h60, 7'h18, 7'h40, 7'h40};
   logic a_exp [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
   always #2 clk = ~clk;
   // Short counts keep the run brief
   hsfc_pins #(.REG_TIMEOUT_CYC(50), .ACT_PULSE_CYC(4)) dut_u (
      .clk(clk), .resetn(resetn), .role(role), .diag_on_indicators(diag), .flow_ctrl_en(flow),
      .spi_select(spi_sel), .sleep_mode(sleep), .hop_pattern(hop), .power_high(1'b0),
      .ack_retry_en(1'b0), .redundant_en(1'b0), .uart_div(udiv), .spi_div(sdiv), .radio_ev(ev),
      .rx_can_accept(can), .spi_data_waiting(waiting), .core_tx_bit(ctx), .core_diagnostic_serial_out_bit(dtx),
      .core_rx_bit(rx_bit), .core_mosi_bit(mosi_bit), .core_diagnostic_serial_in_bit(drx_bit),
      .host_tx_allowed(tx_ok), .activity_indicator(act), .carrier_detect_n(cdn),
      .carrier_detect_in(cd_in), .radio_txd(txd), .radio_rxd(rxd), .spi_mosi(mosi),
      .gpio_active(ga), .gpio_sleep(gs), .gpio_in({rts_n, gin}), .gpio_out(gout), .gpio_oe(goe),
      .gpio_pullup(gpu), .wake_request(wake), .cfg_error(cfg_err));
   hsfc_host_model host_u (.clk(clk), .cts_n(gout[4]), .rts_n(rts_n), .rxd(rxd), .hold_rx(hold));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic pulse(input logic [6:0] e);
      ev = e;
      step(1);
      ev = '0;
   endtask
   task automatic do_reset();
      resetn = 1'b0;
      step(10);
      resetn = 1'b1;
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #40000;
      error_cnt++;
      $display("unexpected at %0t: run hung", $time);
      conclude();
   end
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      int n;
      do_reset();
      chk({act, cdn, txd, gout}, 12'h0C0, "reset pins");
      for (int i = 0; i < 8; i++) begin
         role = hsfc_pkg::hsfc_role_e'(a_role[i]);
         step(1);
         pulse(a_ev[i]);
         n = 0;
         while (act === 1'b1 && n < 9) begin
            n++;
            step(1);
         end
         chk(n >= 4 && n <= 5, a_exp[i], "activity pulse");
         step(2);
      end
      do_reset();
      role = hsfc_pkg::HSFC_ROLE_BASE;
      pulse(7'h40);
      chk(cdn, 1'b0, "base carrier on");
      step(40);
      chk(cdn, 1'b0, "base carrier held");
      n = 0;
      while (cdn !== 1'b1 && n < 20) begin
         n++;
         step(1);
      end
      chk(n >= 8 && n <= 12, 1'b1, "base carrier drop");
      do_reset();
      role = hsfc_pkg::HSFC_ROLE_REMOTE;
      pulse(7'h04);
      chk(cdn, 1'b0, "sync carrier on");
      for (int i = 0; i < 99; i++) begin
         step(1);
         pulse(i == 49 ? 7'h01 : 7'h02);
      end
      step(1);
      chk(cdn, 1'b0, "beacon restarts count");
      pulse(7'h02);
      step(1);
      chk(cdn, 1'b1, "carrier lost");
      diag = 1'b1;
      dtx = 1'b1;
      #1 chk(act, 1'b1, "diag out high");
      step(1);
      dtx = 1'b0;
      cd_in = 1'b0;
      #1 chk(act, 1'b0, "diag out low");
      step(6);
      chk(drx_bit, 1'b0, "diag in");
      cd_in = 1'b1;
      step(6);
      chk(drx_bit, 1'b1, "diag in high");
      diag = 1'b0;
      flow = 1'b1;
      ctx = 1'b0;
      step(6);
      chk({gout[4], rx_bit, txd}, 3'h0, "cts ready");
      chk({goe[5:4], tx_ok, gpu[5:4]}, 5'h0E, "flow pins");
      can = 1'b0;
      step(6);
      chk({gout[4], rx_bit}, 2'h3, "host paused");
      hold = 1'b1;
      step(8);
      chk({txd, tx_ok}, 2'h2, "rts stop");
      hold = 1'b0;
      flow = 1'b0;
      can = 1'b1;
      ga = '{6'h0F, 6'h30, 6'h05, 6'h3F};
      gs = '{6'h00, 6'h3F, 6'h00, 6'h3F};
      step(2);
      chk({goe, gpu}, 12'h3F0, "active cfg");
      chk(gout[3:0], 4'h5, "active level");
      sleep = 1'b1;
      step(6);
      chk({goe, gpu}, 12'h03F, "sleep cfg");
      chk(wake, 1'b0, "pin5 no wake");
      gin = 5'h1E;
      step(6);
      chk(wake, 1'b1, "pin0 wake");
      sleep = 1'b0;
      gin = 5'h1F;
      hop = 4'hB;
      step(1);
      chk(cfg_err, 1'b0, "cfg ok");
      hop = 4'hC;
      step(1);
      chk(cfg_err, 1'b1, "bad pattern");
      hop = 4'h0;
      udiv = 16'h03E7;
      step(1);
      chk(cfg_err, 1'b1, "uart too fast");
      udiv = 16'h03E8;
      sdiv = 16'h01F3;
      step(1);
      chk(cfg_err, 1'b1, "spi too fast");
      sdiv = 16'h01F4;
      step(1);
      spi_sel = 1'b1;
      waiting = 1'b1;
      mosi = 1'b1;
      step(6);
      chk({gout[3], goe[3], txd, mosi_bit, rx_bit}, 5'h1F, "spi pins");
      waiting = 1'b0;
      step(2);
      chk(gout[3], 1'b0, "spi idle");
      conclude();
   end
endmodule // tb
`default_nettype wire
